// *** verilog/tais_pkg.sv ***
/*
 Shared constants and types for the two-axis interpolation sequencer.
 Assumes one 10 MHz system clock and command words from a program sequencer.
*/
package tais_pkg;
   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   typedef enum logic [3:0] {
      CMD_NONE = 4'h0,
      CMD_DUAL_AXIS_HOME_SEARCH = 4'h1,
      CMD_LINEAR_INTERP_MOVE = 4'h2,
      CMD_ARC_CENTER_SET = 4'h3,
      CMD_CLOCKWISE_ARC_MOVE = 4'h4,
      CMD_COUNTERCLOCKWISE_ARC_MOVE = 4'h5,
      CMD_WAIT_DRIVE_FINISH = 4'h6,
      CMD_SINGLE_AXIS_MOVE = 4'h7,
      CMD_STOP = 4'h8,
      CMD_HOME = 4'h9,
      CMD_SPEED = 4'hA,
      CMD_POSITION = 4'hB,
      CMD_SPLIT_PULSE = 4'hC,
      CMD_OTHER = 4'hD
   } tais_cmd_type;

   // ----------------------------------------
   // Speed profile modes
   // ----------------------------------------
   localparam logic [1:0] PROF_CONSTANT = 2'h0;
   localparam logic [1:0] PROF_TRAPEZOID = 2'h1;
   localparam logic [1:0] PROF_SCURVE1 = 2'h2;
   localparam logic [1:0] PROF_SCURVE2 = 2'h3;

   // ----------------------------------------
   // Widths, ranges and timing
   // ----------------------------------------
   localparam int POS_W = 30;
   localparam int RATE_W = 16;
   localparam int ACC_W = 24;
   localparam logic signed [POS_W-1:0] LIN_MAX = 30'sh08000000;
   localparam logic signed [POS_W-1:0] LIN_MIN = -30'sh08000000;
   localparam logic signed [POS_W-1:0] ARC_MAX = 30'sh0FFFFFFF;
   localparam logic signed [POS_W-1:0] ARC_MIN = -30'sh0FFFFFFF;
   localparam int CLK_HZ = 10000000;
   localparam int MIN_SEG_MS = 3;
   localparam int MIN_SEG_CYC = (MIN_SEG_MS * CLK_HZ + 999) / 1000;
   localparam int DRIVE_PULSE_CYC = 2;
   localparam logic [RATE_W-1:0] RAMP_STEP = 16'h0010;
   localparam logic [RATE_W-1:0] RATE_START = 16'h0100;
   localparam logic [15:0] SCALE_RESET = 16'h0001;
endpackage

// *** verilog/tais_pulse_gen.sv ***
/*
 Common timebase for interpolation: phase accumulator clocked by X speed.
 Assumes rate updated synchronously to mclk.
*/
`timescale 1ns/1ps
module tais_pulse_gen (
   input wire logic mclk,
   input wire logic rstN,
   input wire logic enable,
   input wire logic [tais_pkg::RATE_W-1:0] rate,
   output logic tick
);
   logic [tais_pkg::ACC_W-1:0] acc_r;
   logic [tais_pkg::ACC_W:0] sum;

   assign sum = {1'b0, acc_r} + {{(tais_pkg::ACC_W-tais_pkg::RATE_W+1){1'b0}}, rate};

   // ----------------------------------------
   // Accumulator
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         acc_r <= '0;
         tick <= 1'b0;
      end else if (enable) begin
         acc_r <= sum[tais_pkg::ACC_W-1:0];
         tick <= sum[tais_pkg::ACC_W];
      end else begin
         acc_r <= '0;
         tick <= 1'b0;
      end
   end
endmodule // tais_pulse_gen

// *** verilog/tais_scale.sv ***
/*
 Converts position units to drive pulses: value * numerator / denominator.
 Assumes inputs hold steady while start is high, result valid on done.
*/
`timescale 1ns/1ps
module tais_scale (
   input wire logic mclk,
   input wire logic rstN,
   input wire logic start,
   input wire logic signed [tais_pkg::POS_W-1:0] value,
   input wire logic [15:0] numerator,
   input wire logic [15:0] denominator,
   output logic signed [tais_pkg::POS_W-1:0] result,
   output logic done
);
   logic signed [47:0] prod;
   logic signed [47:0] quot;

   assign prod = 48'(value) * $signed({1'b0, numerator});
   assign quot = (denominator == 16'h0000) ? prod : prod / $signed({32'h0, denominator});

   // ----------------------------------------
   // Registered result
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         result <= '0;
         done <= 1'b0;
      end else begin
         done <= start;
         if (start) begin
            result <= quot[tais_pkg::POS_W-1:0];
         end
      end
   end
endmodule // tais_scale

// *** verilog/tais_sequencer.sv ***
/*
 Two-axis interpolation sequencer: executes home, linear, centre and arc lines.
 Assumes the program sequencer holds a line until lineAdvance, and home search
 logic outside reports completion on homeDone.
*/
`timescale 1ns/1ps
module tais_sequencer (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic lineValid,
   input wire logic [3:0] lineCmd,
   input wire logic signed [tais_pkg::POS_W-1:0] lineDataX,
   input wire logic signed [tais_pkg::POS_W-1:0] lineDataY,
   input wire logic [1:0] lineSpeedX,
   input wire logic [1:0] lineSpeedY,
   input wire logic completionPulseSelect,
   input wire logic completionPulseEnable,
   input wire logic [7:0] completionPulseWidth,
   input wire logic [15:0] scaleNumerator,
   input wire logic [15:0] scaleDenominator,
   input wire logic [4*tais_pkg::RATE_W-1:0] presetRate,
   input wire logic [7:0] presetProfile,
   input wire logic homeDone,
   output logic lineAdvance,
   output logic commandError,
   output logic homeStart,
   output logic driveOrCompletionPulseOut,
   output logic xDir,
   output logic yPulse,
   output logic yDir,
   output logic busy
);
   typedef enum {
      ST_IDLE, ST_SCALEX, ST_SCALEY, ST_DISPATCH, ST_HOME, ST_COMPLETION_PULSE_SELECT, ST_ADV
   } tais_state_type;

   logic rstMeta_r, rstN;
   tais_state_type state_r;
   tais_pkg::tais_cmd_type cmd_r;
   logic signed [tais_pkg::POS_W-1:0] relX_r, relY_r, cenX_r, cenY_r;
   logic signed [tais_pkg::POS_W-1:0] remX_r, remY_r, ptX_r, ptY_r;
   logic signed [tais_pkg::POS_W-1:0] errAcc_r, majLen_r, minLen_r;
   logic [31:0] radSq_r;
   logic signed [tais_pkg::POS_W-1:0] scaleIn, scaleOut;
   logic scaleGo, scaleDone;
   logic moving_r, arcMode_r, arcCw_r, fullCircle_r, afterInterp_r, xMajor_r;
   logic [tais_pkg::RATE_W-1:0] rate_r, targetRate_r;
   logic [1:0] profile_r;
   logic [7:0] pulseCnt_r, stepCnt_r;
   logic tick;
   logic signed [tais_pkg::POS_W-1:0] startDx_r, startDy_r;

   function automatic logic is_interp(input logic [3:0] c);
      is_interp = (c == tais_pkg::CMD_LINEAR_INTERP_MOVE) || (c == tais_pkg::CMD_ARC_CENTER_SET)
         || (c == tais_pkg::CMD_CLOCKWISE_ARC_MOVE) || (c == tais_pkg::CMD_COUNTERCLOCKWISE_ARC_MOVE);
   endfunction

   function automatic logic forbidden_after(input logic [3:0] c);
      forbidden_after = (c == tais_pkg::CMD_SINGLE_AXIS_MOVE) || (c == tais_pkg::CMD_STOP)
         || (c == tais_pkg::CMD_HOME) || (c == tais_pkg::CMD_DUAL_AXIS_HOME_SEARCH)
         || (c == tais_pkg::CMD_SPEED) || (c == tais_pkg::CMD_POSITION) || (c == tais_pkg::CMD_SPLIT_PULSE);
   endfunction

   function automatic logic signed [tais_pkg::POS_W-1:0] abs_v(input logic signed [tais_pkg::POS_W-1:0] v);
      abs_v = v[tais_pkg::POS_W-1] ? -v : v;
   endfunction

   function automatic logic signed [tais_pkg::POS_W-1:0] sign_v(input logic signed [tais_pkg::POS_W-1:0] v);
      if (v == '0) sign_v = '0;
      else if (v[tais_pkg::POS_W-1]) sign_v = -30'sd1;
      else sign_v = 30'sd1;
   endfunction

   function automatic logic [31:0] sq_sum(input logic signed [tais_pkg::POS_W-1:0] a,
                                          input logic signed [tais_pkg::POS_W-1:0] b);
      logic [59:0] s;
      s = 60'(a * a) + 60'(b * b);
      sq_sum = s[31:0];
   endfunction

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_r <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstN <= rstMeta_r;
      end
   end

   assign scaleGo = (state_r == ST_SCALEX) || (state_r == ST_SCALEY);
   assign scaleIn = (state_r == ST_SCALEX) ? lineDataX : lineDataY;

   tais_scale uScale (
      .mclk(mclk),
      .rstN(rstN),
      .start(scaleGo),
      .value(scaleIn),
      .numerator(scaleNumerator),
      .denominator(scaleDenominator),
      .result(scaleOut),
      .done(scaleDone)
   );

   tais_pulse_gen uTimebase (
      .mclk(mclk),
      .rstN(rstN),
      .enable(moving_r),
      .rate(rate_r),
      .tick(tick)
   );

   // ----------------------------------------
   // Line sequencing
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         state_r <= ST_IDLE;
         cmd_r <= tais_pkg::CMD_NONE;
         relX_r <= '0;
         relY_r <= '0;
         lineAdvance <= 1'b0;
         commandError <= 1'b0;
         homeStart <= 1'b0;
         afterInterp_r <= 1'b0;
         pulseCnt_r <= '0;
      end else begin
         lineAdvance <= 1'b0;
         homeStart <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (lineValid && !lineAdvance) begin
                  cmd_r <= tais_pkg::tais_cmd_type'(lineCmd);
                  if (afterInterp_r && forbidden_after(lineCmd)) begin
                     commandError <= 1'b1;
                     state_r <= ST_ADV;
                  end else begin
                     commandError <= 1'b0;
                     state_r <= ST_SCALEX;
                  end
               end
            end
            ST_SCALEX: state_r <= ST_SCALEY;
            ST_SCALEY: begin
               relX_r <= scaleOut;
               state_r <= ST_DISPATCH;
            end
            ST_DISPATCH: begin
               relY_r <= scaleOut;
               if (cmd_r == tais_pkg::CMD_DUAL_AXIS_HOME_SEARCH) begin
                  homeStart <= 1'b1;
                  state_r <= ST_HOME;
               end else if (is_interp(cmd_r) && moving_r && cmd_r != tais_pkg::CMD_ARC_CENTER_SET) begin
                  state_r <= ST_DISPATCH;
               end else if (cmd_r == tais_pkg::CMD_WAIT_DRIVE_FINISH && moving_r) begin
                  state_r <= ST_DISPATCH;
               end else begin
                  state_r <= ST_ADV;
               end
               if (!(moving_r && is_interp(cmd_r)))
                  afterInterp_r <= is_interp(cmd_r);
            end
            ST_HOME: begin
               if (homeDone) begin
                  pulseCnt_r <= completionPulseWidth;
                  state_r <= (completionPulseSelect && completionPulseEnable) ? ST_COMPLETION_PULSE_SELECT : ST_ADV;
               end
            end
            ST_COMPLETION_PULSE_SELECT: begin
               if (pulseCnt_r <= 8'h01) begin
                  state_r <= ST_ADV;
               end
               pulseCnt_r <= pulseCnt_r - 8'h01;
            end
            ST_ADV: begin
               lineAdvance <= 1'b1;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Motion start and speed profile
   // ----------------------------------------
   logic startMove;
   assign startMove = (state_r == ST_DISPATCH) && !moving_r && (cmd_r == tais_pkg::CMD_LINEAR_INTERP_MOVE
      || cmd_r == tais_pkg::CMD_CLOCKWISE_ARC_MOVE || cmd_r == tais_pkg::CMD_COUNTERCLOCKWISE_ARC_MOVE);

   logic [1:0] selProfile;
   logic [tais_pkg::RATE_W-1:0] selRate;
   assign selProfile = presetProfile[lineSpeedX*2 +: 2];
   assign selRate = presetRate[lineSpeedX*tais_pkg::RATE_W +: tais_pkg::RATE_W];

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         rate_r <= '0;
         targetRate_r <= '0;
         profile_r <= tais_pkg::PROF_CONSTANT;
      end else if (startMove) begin
         targetRate_r <= selRate;
         if (cmd_r == tais_pkg::CMD_LINEAR_INTERP_MOVE && selProfile == tais_pkg::PROF_TRAPEZOID) begin
            profile_r <= tais_pkg::PROF_TRAPEZOID;
            rate_r <= (selRate < tais_pkg::RATE_START) ? selRate : tais_pkg::RATE_START;
         end else begin
            profile_r <= tais_pkg::PROF_CONSTANT;
            rate_r <= selRate;
         end
      end else if (moving_r && profile_r == tais_pkg::PROF_TRAPEZOID && tick) begin
         if (32'(remX_r + remY_r) <= 32'(stepCnt_r) && rate_r > tais_pkg::RATE_START)
            rate_r <= rate_r - tais_pkg::RAMP_STEP;
         else if (rate_r < targetRate_r)
            rate_r <= rate_r + tais_pkg::RAMP_STEP;
      end
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         stepCnt_r <= '0;
      end else if (startMove) begin
         stepCnt_r <= '0;
      end else if (moving_r && tick && rate_r < targetRate_r && stepCnt_r != 8'hFF) begin
         stepCnt_r <= stepCnt_r + 8'h01;
      end
   end

   // ----------------------------------------
   // Arc centre
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         cenX_r <= '0;
         cenY_r <= '0;
      end else if (state_r == ST_DISPATCH && cmd_r == tais_pkg::CMD_ARC_CENTER_SET) begin
         cenX_r <= relX_r;
         cenY_r <= scaleOut;
      end
   end

   // ----------------------------------------
   // Path generation on common timebase
   // ----------------------------------------
   logic signed [tais_pkg::POS_W-1:0] tanX, tanY, nxtX, nxtY;
   logic signed [32:0] errX, errY;
   logic stepX, stepY;
   assign nxtX = stepX ? ptX_r + tanX : ptX_r;
   assign nxtY = stepY ? ptY_r + tanY : ptY_r;
   always_comb begin
      tanX = arcCw_r ? sign_v(ptY_r) : -sign_v(ptY_r);
      tanY = arcCw_r ? -sign_v(ptX_r) : sign_v(ptX_r);
      errX = $signed({1'b0, sq_sum(ptX_r + tanX, ptY_r)}) - $signed({1'b0, radSq_r});
      errY = $signed({1'b0, sq_sum(ptX_r, ptY_r + tanY)}) - $signed({1'b0, radSq_r});
      stepX = 1'b0;
      stepY = 1'b0;
      if (arcMode_r) begin
         // Tangent step nearest the circle
         if (tanY == '0) stepX = 1'b1;
         else if (tanX == '0) stepY = 1'b1;
         else if ((errX[32] ? -errX : errX) <= (errY[32] ? -errY : errY)) stepX = 1'b1;
         else stepY = 1'b1;
      end else begin
         if (xMajor_r) begin
            stepX = 1'b1;
            stepY = (2 * (errAcc_r + minLen_r) >= majLen_r);
         end else begin
            stepY = 1'b1;
            stepX = (2 * (errAcc_r + minLen_r) >= majLen_r);
         end
      end
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         moving_r <= 1'b0;
         arcMode_r <= 1'b0;
         arcCw_r <= 1'b0;
         fullCircle_r <= 1'b0;
         xMajor_r <= 1'b0;
         remX_r <= '0;
         remY_r <= '0;
         ptX_r <= '0;
         ptY_r <= '0;
         errAcc_r <= '0;
         majLen_r <= '0;
         minLen_r <= '0;
         radSq_r <= '0;
         startDx_r <= '0;
         startDy_r <= '0;
         xDir <= 1'b0;
         yDir <= 1'b0;
         driveOrCompletionPulseOut <= 1'b0;
         yPulse <= 1'b0;
      end else begin
         driveOrCompletionPulseOut <= (state_r == ST_COMPLETION_PULSE_SELECT);
         yPulse <= 1'b0;
         if (startMove) begin
            moving_r <= 1'b1;
            arcMode_r <= (cmd_r != tais_pkg::CMD_LINEAR_INTERP_MOVE);
            arcCw_r <= (cmd_r == tais_pkg::CMD_CLOCKWISE_ARC_MOVE);
            fullCircle_r <= (relX_r == '0) && (scaleOut == '0);
            remX_r <= abs_v(relX_r);
            remY_r <= abs_v(scaleOut);
            xDir <= !relX_r[tais_pkg::POS_W-1];
            yDir <= !scaleOut[tais_pkg::POS_W-1];
            xMajor_r <= abs_v(relX_r) >= abs_v(scaleOut);
            majLen_r <= (abs_v(relX_r) >= abs_v(scaleOut)) ? abs_v(relX_r) : abs_v(scaleOut);
            minLen_r <= (abs_v(relX_r) >= abs_v(scaleOut)) ? abs_v(scaleOut) : abs_v(relX_r);
            errAcc_r <= '0;
            ptX_r <= -cenX_r;
            ptY_r <= -cenY_r;
            startDx_r <= relX_r - cenX_r;
            startDy_r <= scaleOut - cenY_r;
            radSq_r <= sq_sum(cenX_r, cenY_r);
         end else if (moving_r && tick) begin
            if (!arcMode_r) begin
               if (stepX && remX_r != '0) begin
                  remX_r <= remX_r - 30'sd1;
               end
               if (stepY && remY_r != '0) begin
                  remY_r <= remY_r - 30'sd1;
                  yPulse <= 1'b1;
               end
               errAcc_r <= (2 * (errAcc_r + minLen_r) >= majLen_r) ? errAcc_r + minLen_r - majLen_r
                           : errAcc_r + minLen_r;
               if ((remX_r == '0 || (stepX && remX_r == 30'sd1)) && (remY_r == '0 || (stepY && remY_r == 30'sd1)))
                  moving_r <= 1'b0;
            end else begin
               ptX_r <= nxtX;
               ptY_r <= nxtY;
               if (stepX) begin
                  xDir <= !tanX[tais_pkg::POS_W-1];
               end else begin
                  yDir <= !tanY[tais_pkg::POS_W-1];
                  yPulse <= 1'b1;
               end
               // Exact finish on axes, else within one pulse
               if ((nxtX == startDx_r && nxtY == startDy_r && (!fullCircle_r || errAcc_r != '0))
                   || (((cenX_r != '0 && cenY_r != '0) || (startDx_r != '0 && startDy_r != '0))
                   && errAcc_r > 30'sd2 && abs_v(nxtX - startDx_r) <= 30'sd1
                   && abs_v(nxtY - startDy_r) <= 30'sd1))
                  moving_r <= 1'b0;
               errAcc_r <= errAcc_r + 30'sd1;
            end
         end
      end
   end

   // ----------------------------------------
   // Status
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         busy <= 1'b0;
      end else begin
         busy <= moving_r || (state_r != ST_IDLE);
      end
   end
endmodule // tais_sequencer

// *** bench/tais_motor_stage.sv ***
/*
 Power stage model: counts Y steps and measures completion pulses.
 Assumes pulses and directions change on rising mclk.
*/
`timescale 1ns/1ps
module tais_motor_stage (
   input wire logic mclk,
   input wire logic yPulse,
   input wire logic yDir,
   input wire logic endPulse,
   output int yPos,
   output int yCount,
   output int pulseTotal,
   output int lastWidth
);
   int widthCnt = 0;
   initial begin
      yPos = 0;
      yCount = 0;
      pulseTotal = 0;
      lastWidth = 0;
   end
   // ----------------------------------------
   // Step and pulse accounting
   // ----------------------------------------
   always @(posedge mclk) begin
      if (yPulse === 1'b1) begin
         yCount <= yCount + 1;
         yPos <= yPos + ((yDir === 1'b1) ? 1 : -1);
      end
      if (endPulse === 1'b1) begin
         widthCnt <= widthCnt + 1;
      end else if (widthCnt != 0) begin
         lastWidth <= widthCnt;
         pulseTotal <= pulseTotal + 1;
         widthCnt <= 0;
      end
   end
endmodule // tais_motor_stage

// *** bench/tais_sequencer_assertions.sv ***
/*
 Port checker for the sequencer.
 Assumes it is bound to the top module; nrst active low.
*/
`timescale 1ns/1ps
module tais_seq_assertions (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic lineValid,
   input wire logic [3:0] lineCmd,
   input wire logic completionPulseSelect,
   input wire logic completionPulseEnable,
   input wire logic [7:0] completionPulseWidth,
   input wire logic homeDone,
   input wire logic lineAdvance,
   input wire logic commandError,
   input wire logic homeStart,
   input wire logic driveOrCompletionPulseOut,
   input wire logic yPulse,
   input wire logic busy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic homePend_r;
   logic [8:0] pulseCnt_r;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) homePend_r <= 1'b0;
      else if (homeStart) homePend_r <= 1'b1;
      else if (homeDone) homePend_r <= 1'b0;
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) pulseCnt_r <= 9'h000;
      else if (driveOrCompletionPulseOut) pulseCnt_r <= pulseCnt_r + 9'h001;
      else pulseCnt_r <= 9'h000;
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_home_start;
      $rose(lineValid) && !busy && lineCmd == tais_pkg::CMD_DUAL_AXIS_HOME_SEARCH |-> ##[1:8] homeStart;
   endproperty
   a_home_start: assert property (p_home_start) else $error("home search not started");
   property p_home_wait;
      homePend_r && !homeDone |-> !lineAdvance;
   endproperty
   a_home_wait: assert property (p_home_wait) else $error("advance before home finished");
   property p_pulse_cond;
      $rose(driveOrCompletionPulseOut) |-> completionPulseSelect && completionPulseEnable;
   endproperty
   a_pulse_cond: assert property (p_pulse_cond) else $error("completion pulse not allowed");
   property p_pulse_width;
      $fell(driveOrCompletionPulseOut) |->
         pulseCnt_r == ((completionPulseWidth == 8'h00) ? 9'h001 : {1'b0, completionPulseWidth});
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("completion pulse width wrong");
   property p_center_adv;
      $rose(lineValid) && !busy && lineCmd == tais_pkg::CMD_ARC_CENTER_SET |-> ##[4:5] lineAdvance;
   endproperty
   a_center_adv: assert property (p_center_adv) else $error("centre line not advanced");
   property p_move_adv;
      $rose(lineValid) && !busy && (lineCmd inside {tais_pkg::CMD_LINEAR_INTERP_MOVE,
         tais_pkg::CMD_CLOCKWISE_ARC_MOVE, tais_pkg::CMD_COUNTERCLOCKWISE_ARC_MOVE}) |-> ##[1:8] lineAdvance;
   endproperty
   a_move_adv: assert property (p_move_adv) else $error("move line not advanced at start");
   property p_adv_one;
      lineAdvance |=> !lineAdvance;
   endproperty
   a_adv_one: assert property (p_adv_one) else $error("advance longer than one cycle");
   property p_step_busy;
      yPulse |-> busy;
   endproperty
   a_step_busy: assert property (p_step_busy) else $error("step while idle");
   property p_err_hold;
      $fell(commandError) |-> $past(lineValid);
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error cleared without line");
endmodule // tais_seq_assertions

// *** bench/tais_sequencer_tb.sv ***
/*
 Self-checking bench for the sequencer with a power stage model.
 Assumes a 10 MHz clock and home search answered by the bench.
*/
`timescale 1ns/1ps
module tais_sequencer_tb;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic lineValid = 1'b0;
   logic [3:0] lineCmd = 4'h0;
   logic signed [tais_pkg::POS_W-1:0] lineDataX = '0;
   logic signed [tais_pkg::POS_W-1:0] lineDataY = '0;
   logic [1:0] lineSpeedX = 2'h0;
   logic [1:0] lineSpeedY = 2'h0;
   logic completionPulseSelect = 1'b0;
   logic completionPulseEnable = 1'b0;
   logic [7:0] completionPulseWidth = 8'h01;
   logic [15:0] scaleNumerator = 16'h0001;
   logic [15:0] scaleDenominator = 16'h0001;
   logic [63:0] presetRate = {16'hF000, 16'hE000, 16'hFFFF, 16'hF800};
   logic [7:0] presetProfile = 8'h08;
   logic homeDone = 1'b0;
   logic lineAdvance, commandError, homeStart, driveOrCompletionPulseOut, xDir, yPulse, yDir, busy;
   int yPos, yCount, pulseTotal, lastWidth;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   int w, d, p, y0, c0;
   tais_sequencer dut_u (.mclk(mclk), .nrst(nrst), .lineValid(lineValid), .lineCmd(lineCmd),
      .lineDataX(lineDataX), .lineDataY(lineDataY), .lineSpeedX(lineSpeedX), .lineSpeedY(lineSpeedY),
      .completionPulseSelect(completionPulseSelect), .completionPulseEnable(completionPulseEnable),
      .completionPulseWidth(completionPulseWidth), .scaleNumerator(scaleNumerator),
      .scaleDenominator(scaleDenominator), .presetRate(presetRate), .presetProfile(presetProfile),
      .homeDone(homeDone), .lineAdvance(lineAdvance), .commandError(commandError), .homeStart(homeStart),
      .driveOrCompletionPulseOut(driveOrCompletionPulseOut), .xDir(xDir), .yPulse(yPulse), .yDir(yDir),
      .busy(busy));
   tais_motor_stage stage_u (.mclk(mclk), .yPulse(yPulse), .yDir(yDir), .endPulse(driveOrCompletionPulseOut),
      .yPos(yPos), .yCount(yCount), .pulseTotal(pulseTotal), .lastWidth(lastWidth));
   always #50 mclk = ~mclk;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic send(logic [3:0] c, int dx, int dy);
      int n;
      n = 0;
      @(negedge mclk);
      lineCmd = c;
      lineDataX = tais_pkg::POS_W'(dx);
      lineDataY = tais_pkg::POS_W'(dy);
      lineSpeedX = 2'($urandom_range(3));
      lineSpeedY = 2'($urandom_range(3));
      lineValid = 1'b1;
      while (lineAdvance !== 1'b1 && n < 20000) begin
         @(negedge mclk);
         n++;
      end
      lineValid = 1'b0;
      check("lineAdvance", {31'h0, lineAdvance}, 32'h1);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 20000) begin
         @(negedge mclk);
         n++;
      end
      repeat (3) @(negedge mclk);
   endtask
   always begin
      @(negedge mclk);
      if (homeStart === 1'b1) begin
         repeat (6) @(negedge mclk);
         homeDone = 1'b1;
         @(negedge mclk);
         homeDone = 1'b0;
      end
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 90000) begin
         err_total++;
         finish_test();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(4206));
      repeat (12) @(negedge mclk);
      nrst = 1'b1;
      repeat (3) @(negedge mclk);
      for (int i = 0; i < 3; i++) begin
         w = $urandom_range(8, 1);
         completionPulseWidth = 8'(w);
         completionPulseSelect = (i != 1);
         completionPulseEnable = (i != 2);
         p = pulseTotal;
         send(tais_pkg::CMD_DUAL_AXIS_HOME_SEARCH, 0, 0);
         repeat (w + 3) @(negedge mclk);
         check("pulses", pulseTotal - p, (i == 0) ? 1 : 0);
         if (i == 0) check("width", lastWidth, w);
      end
      for (int i = 0; i < 4; i++) begin
         d = $urandom_range(6, 1);
         d = (i % 2 == 1) ? -d : d;
         scaleNumerator = (i == 3) ? 16'h0002 : 16'h0001;
         y0 = yPos;
         send(tais_pkg::CMD_LINEAR_INTERP_MOVE, $urandom_range(6), d);
         wait_idle();
         check("linear y", yPos - y0, d * ((i == 3) ? 2 : 1));
      end
      scaleNumerator = 16'h0001;
      send(tais_pkg::CMD_LINEAR_INTERP_MOVE, 3, 3);
      send(tais_pkg::CMD_STOP, 0, 0);
      check("error set", {31'h0, commandError}, 32'h1);
      wait_idle();
      for (int i = 0; i < 3; i++) begin
         send(tais_pkg::CMD_ARC_CENTER_SET, 4, 0);
         if (i == 0) check("error clear", {31'h0, commandError}, 32'h0);
         y0 = yPos;
         c0 = yCount;
         if (i == 0) send(tais_pkg::CMD_CLOCKWISE_ARC_MOVE, 4, 4);
         else if (i == 1) send(tais_pkg::CMD_COUNTERCLOCKWISE_ARC_MOVE, 4, -4);
         else send(tais_pkg::CMD_CLOCKWISE_ARC_MOVE, 0, 0);
         wait_idle();
         check("arc y", yPos - y0, (i == 0) ? 4 : ((i == 1) ? -4 : 0));
         check("arc steps", yCount - c0, (i == 2) ? 16 : 4);
      end
      finish_test();
   end
endmodule // tais_sequencer_tb
bind tais_sequencer tais_seq_assertions chk_u (.mclk(mclk), .nrst(nrst), .lineValid(lineValid),
   .lineCmd(lineCmd), .completionPulseSelect(completionPulseSelect),
   .completionPulseEnable(completionPulseEnable), .completionPulseWidth(completionPulseWidth),
   .homeDone(homeDone), .lineAdvance(lineAdvance), .commandError(commandError), .homeStart(homeStart),
   .driveOrCompletionPulseOut(driveOrCompletionPulseOut), .yPulse(yPulse), .busy(busy));
